//--- verilog/forced_powerdown_and_chip_gating.sv
// Purpose: power-down control, chip-select gating and logic-array mode
// Assumes: host writes the control window with a one-cycle strobe
// Notes:   all outputs are registered; selects lag requests by one or two cycles
`timescale 1ns/1ps

module forced_powerdown_and_chip_gating
  import power_gate_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // control register window
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // configuration
  input wire logic csi_configured,
  input wire logic low_voltage_part,
  // pins from outside the clock domain
  input wire logic ale,
  input wire logic common_clock_input,
  input wire logic csi_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic psen_n,
  input wire logic pc7,
  // memory selects: main_flash, boot_flash, sram, register window
  input wire logic [N_SEL-1:0] sel_request,
  output logic [N_SEL-1:0] mem_select,
  // host bus gating
  output logic fetch_enable,
  output logic host_bus_block,
  // logic array input bus and mode
  input wire logic [7:0] logic_array_in,
  output logic [7:0] logic_array_out,
  output logic [4:0] logic_input_bus,
  output logic fast_mode,
  output logic logic_standby,
  output logic csi_pin_level,
  // status
  output logic powerdown_indicator
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [N_PINS-1:0] pins_raw;
  logic [N_PINS-1:0] pins;
  logic [N_PINS-1:0] pins_q;
  logic [N_PINS-1:0] pin_rst;

  assign pins_raw = {pc7, psen_n, wr_n, rd_n, csi_n, common_clock_input, ale};
  // active-low strobes and chip select idle high; ale and pc7 idle low
  assign pin_rst = {1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  genvar gi;
  generate
    for (gi = 0; gi < N_PINS; gi++) begin : g_sync
      pin_sync3 u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .pin(pins_raw[gi]),
        .rst_level(pin_rst[gi]),
        .level(pins[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pins_q <= pin_rst;
    end else begin
      pins_q <= pins;
    end
  end

  logic ale_toggle;
  logic common_clock_input_rise;
  logic csi_fall;
  assign ale_toggle = pins[PIN_ALE] ^ pins_q[PIN_ALE];
  assign common_clock_input_rise = pins[PIN_COMMON_CLOCK_INPUT] & ~pins_q[PIN_COMMON_CLOCK_INPUT];
  assign csi_fall = csi_configured & pins_q[PIN_CSI_N] & ~pins[PIN_CSI_N];

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = reg_wr && (addr == ofs);
  endfunction

  logic [7:0] mode_reg_zero;
  logic [7:0] mode_reg_two;
  logic force_powerdown_bit;
  logic force_set;

  assign force_set = hit(reg_addr, OFS_POWER_MODE_REG_THREE) && reg_wdata[BIT_FORCE];

  // reset clears all; the force bit ignores written zeros
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mode_reg_zero <= REG_RESET;
      mode_reg_two <= REG_RESET;
      force_powerdown_bit <= 1'b0;
    end else begin
      if (hit(reg_addr, OFS_POWER_MODE_REG_ZERO)) begin
        mode_reg_zero <= reg_wdata;
      end
      if (hit(reg_addr, OFS_POWER_MODE_REG_TWO)) begin
        mode_reg_two <= reg_wdata & MASK_REG_TWO;
      end
      if (force_set) begin
        force_powerdown_bit <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      reg_rdata <= REG_RESET;
    end else begin
      unique case (reg_addr)
        OFS_POWER_MODE_REG_ZERO: reg_rdata <= mode_reg_zero;
        OFS_POWER_MODE_REG_TWO: reg_rdata <= mode_reg_two;
        OFS_POWER_MODE_REG_THREE: reg_rdata <= 8'(force_powerdown_bit) << BIT_FORCE;
        default: reg_rdata <= REG_RESET;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // auto idle counter
  // ---------------------------------------------------------------
  logic [3:0] auto_idle_count;
  logic auto_idle_powerdown;
  assign auto_idle_powerdown = (auto_idle_count == AUTO_IDLE_MAX);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      auto_idle_count <= 4'h0_000;
    end else if (!mode_reg_zero[BIT_AUTO_ENABLE] || ale_toggle) begin
      auto_idle_count <= 4'h0_000;
    end else if (common_clock_input_rise && !auto_idle_powerdown) begin
      auto_idle_count <= auto_idle_count + 4'h0_001;
    end
  end

  // ---------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------
  power_state_e state;
  power_state_e next_state;
  logic wake;

  // a forced entry in the same cycle as a wake event still enters
  assign wake = ale_toggle | csi_fall;

  always_comb begin
    next_state = state;
    unique case (state)
      st_run: begin
        if (force_set) begin
          next_state = st_down;
        end else if (auto_idle_powerdown && !ale_toggle) begin
          next_state = st_down;
        end
      end
      st_down: begin
        if (wake && !force_set) begin
          next_state = st_run;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= st_run;
    end else begin
      state <= next_state;
    end
  end

  logic down;
  assign down = (next_state == st_down);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      powerdown_indicator <= 1'b0;
      fetch_enable <= 1'b1;
      host_bus_block <= 1'b0;
    end else begin
      powerdown_indicator <= down;
      fetch_enable <= !down;
      host_bus_block <= down;
    end
  end

  // ---------------------------------------------------------------
  // chip select gating and memory selects
  // ---------------------------------------------------------------
  logic csi_allow;
  logic [N_SEL-1:0] sel_stage;
  // unconfigured pin never gates selects
  assign csi_allow = !csi_configured || !pins[PIN_CSI_N];

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sel_stage <= '0;
      mem_select <= '0;
    end else begin
      sel_stage <= (csi_allow && !down) ? sel_request : '0;
      // slow mode pays one extra cycle through the decode array
      mem_select <= (csi_allow && !down) ? (fast_mode ? sel_request : sel_stage) : '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      csi_pin_level <= 1'b1;
    end else begin
      csi_pin_level <= pins[PIN_CSI_N];
    end
  end

  // ---------------------------------------------------------------
  // logic array input bus, mode and standby latch
  // ---------------------------------------------------------------
  logic [4:0] next_input_bus;
  always_comb begin
    next_input_bus[0] = pins[PIN_WR_N] & ~mode_reg_two[BIT_BLOCK_WR];
    next_input_bus[1] = pins[PIN_RD_N] & ~mode_reg_two[BIT_BLOCK_RD];
    next_input_bus[2] = pins[PIN_PSEN_N] & ~mode_reg_two[BIT_BLOCK_PSEN];
    next_input_bus[3] = pins[PIN_ALE] & ~mode_reg_two[BIT_BLOCK_ALE] & ~down;
    next_input_bus[4] = pins[PIN_PC7] & ~mode_reg_two[BIT_BLOCK_PC7];
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      logic_input_bus <= 5'h0_000;
      fast_mode <= 1'b1;
    end else begin
      logic_input_bus <= next_input_bus;
      fast_mode <= !mode_reg_zero[BIT_FAST_OFF];
    end
  end

  logic [7:0] array_in_q;
  logic [4:0] bus_q;
  logic [3:0] idle_count;
  logic [3:0] idle_limit;
  logic inputs_moved;

  assign idle_limit = low_voltage_part ? IDLE_CNT_3V3 : IDLE_CNT_5V;
  assign inputs_moved = (array_in_q != logic_array_in) || (bus_q != logic_input_bus);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      array_in_q <= 8'h0_000;
      bus_q <= 5'h0_000;
      idle_count <= 4'h0_000;
    end else begin
      array_in_q <= logic_array_in;
      bus_q <= logic_input_bus;
      if (inputs_moved || fast_mode) begin
        idle_count <= 4'h0_000;
      end else if (idle_count != idle_limit) begin
        idle_count <= idle_count + 4'h0_001;
      end
    end
  end

  // outputs are frozen in standby; chip select never touches them
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      logic_standby <= 1'b0;
      logic_array_out <= 8'h0_000;
    end else begin
      logic_standby <= !fast_mode && !inputs_moved && (idle_count == idle_limit);
      if (fast_mode || inputs_moved) begin
        logic_array_out <= logic_array_in;
      end else if (!logic_standby) begin
        logic_array_out <= array_in_q;
      end
    end
  end

endmodule

//--- verilog/power_gate_pkg.sv
// Purpose: shared constants for the power-down and chip-gating block
// Assumes: 8-bit control register window, 20 MHz system clock
// Notes:   offsets are byte offsets inside the control register window
package power_gate_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int IDLE_NS_5V = 65;
  localparam int IDLE_NS_3V3 = 100;
  // least times round up to whole cycles
  localparam int IDLE_CYC_5V = (IDLE_NS_5V + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_CYC_3V3 = (IDLE_NS_3V3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] IDLE_CNT_5V = 4'(IDLE_CYC_5V);
  localparam logic [3:0] IDLE_CNT_3V3 = 4'(IDLE_CYC_3V3);
  localparam logic [3:0] AUTO_IDLE_MAX = 4'h0_00F;

  // ---------------------------------------------------------------
  // register window
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_POWER_MODE_REG_ZERO = 8'h0_0B0;
  localparam logic [7:0] OFS_POWER_MODE_REG_TWO = 8'h0_0B4;
  localparam logic [7:0] OFS_POWER_MODE_REG_THREE = 8'h0_0C7;
  localparam logic [7:0] REG_RESET = 8'h0_000;

  // power_mode_reg_zero fields
  localparam int BIT_AUTO_ENABLE = 1;
  localparam int BIT_FAST_OFF = 3;
  // power_mode_reg_two blocking fields
  localparam int BIT_BLOCK_WR = 2;
  localparam int BIT_BLOCK_RD = 3;
  localparam int BIT_BLOCK_PSEN = 4;
  localparam int BIT_BLOCK_ALE = 5;
  localparam int BIT_BLOCK_PC7 = 6;
  localparam logic [7:0] MASK_REG_TWO = 8'h0_07C;
  // power_mode_reg_three fields
  localparam int BIT_FORCE = 1;

  // ---------------------------------------------------------------
  // pins and selects
  // ---------------------------------------------------------------
  localparam int N_PINS = 7;
  localparam int PIN_ALE = 0;
  localparam int PIN_COMMON_CLOCK_INPUT = 1;
  localparam int PIN_CSI_N = 2;
  localparam int PIN_RD_N = 3;
  localparam int PIN_WR_N = 4;
  localparam int PIN_PSEN_N = 5;
  localparam int PIN_PC7 = 6;
  localparam int N_SEL = 4;

  typedef enum logic [1:0] {
    st_run = 2'b01,
    st_down = 2'b10
  } power_state_e;

endpackage

//--- verilog/pin_sync3.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input is asynchronous to clk_sys
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
module pin_sync3 (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // pin and filtered level
  input wire logic pin,
  input wire logic rst_level,
  output logic level
);

  logic s1;
  logic s2;
  logic s3;

  // first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      // stages start at the idle level so release gives no false edge
      s1 <= rst_level;
      s2 <= rst_level;
      s3 <= rst_level;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      level <= rst_level;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end

endmodule

//--- verification/power_gate_properties.sv
// Purpose: port-level checks of the power gating block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to the block below the module
`timescale 1ns/1ps
module power_gate_checker
  import power_gate_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // watched ports
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic csi_configured,
  input wire logic [N_SEL-1:0] sel_request,
  input wire logic [N_SEL-1:0] mem_select,
  input wire logic fetch_enable,
  input wire logic host_bus_block,
  input wire logic [7:0] logic_array_out,
  input wire logic [4:0] logic_input_bus,
  input wire logic fast_mode,
  input wire logic logic_standby,
  input wire logic csi_pin_level,
  input wire logic powerdown_indicator
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // sequences and checks
  // ----------------------------------------
  sequence force_wr;
    reg_wr && reg_addr == OFS_POWER_MODE_REG_THREE && reg_wdata[BIT_FORCE];
  endsequence
  // a quiet cycle after the write keeps a later write from masking the effect
  sequence wr_quiet(logic [7:0] ofs);
    reg_wr && reg_addr == ofs ##1 !reg_wr;
  endsequence
  a_force_enters_down: assert property (force_wr |=> powerdown_indicator)
    else $error("no power-down after force write");
  a_down_stops_fetch: assert property (powerdown_indicator |-> !fetch_enable)
    else $error("fetch served in power-down");
  a_down_blocks_bus: assert property (powerdown_indicator |-> host_bus_block && !mem_select)
    else $error("host bus open in power-down");
  a_force_bit_sticks: assert property ((reg_addr == OFS_POWER_MODE_REG_THREE)[*2]
      ##0 reg_rdata[BIT_FORCE] |=> reg_rdata[BIT_FORCE])
    else $error("force bit cleared without reset");
  a_csi_high_gates: assert property ((csi_configured && csi_pin_level)[*4] |-> !mem_select)
    else $error("select active while chip select high");
  a_open_select_pass: assert property ((fast_mode && !csi_configured)[*2]
      ##0 !powerdown_indicator |-> mem_select == $past(sel_request))
    else $error("select did not follow request");
  a_mode_bit_write: assert property (wr_quiet(OFS_POWER_MODE_REG_ZERO)
      |=> fast_mode == !$past(reg_wdata[BIT_FAST_OFF], 2))
    else $error("fast mode does not follow mode bit");
  a_ale_blocked: assert property (wr_quiet(OFS_POWER_MODE_REG_TWO)
      |=> !$past(reg_wdata[BIT_BLOCK_ALE], 2) || !logic_input_bus[3])
    else $error("blocked strobe reached logic bus");
  a_standby_holds: assert property (logic_standby && $past(logic_standby)
      |-> $stable(logic_array_out))
    else $error("outputs moved in standby");
endmodule

bind forced_powerdown_and_chip_gating power_gate_checker power_gate_checker_inst (
  .clk_sys, .rstn, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .csi_configured,
  .sel_request, .mem_select, .fetch_enable, .host_bus_block, .logic_array_out,
  .logic_input_bus, .fast_mode, .logic_standby, .csi_pin_level, .powerdown_indicator);

//--- verification/host_model.sv
// Purpose: host core and external chip-select driver
// Assumes: requests change on the falling edge
// Notes: write data is inverted once released
`timescale 1ns/1ps
module host_model
  import power_gate_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // register window
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // strobes and select
  output logic ale,
  output logic common_clock_input,
  output logic csi_n
);
  logic ale_run;
  logic ale_phase;
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h0_000;
    reg_wdata = 8'h0_000;
    ale = 1'b0;
    common_clock_input = 1'b0;
    csi_n = 1'b0;
    ale_run = 1'b1;
    ale_phase = 1'b0;
  end
  // each level stands two cycles: the pin filter drops a strobe that flips every cycle
  always @(negedge clk_sys) begin
    if (ale_run) begin
      ale_phase <= ~ale_phase;
      if (ale_phase) begin
        ale <= ~ale;
      end
    end
  end
  // common clock levels stand two cycles each so the pin filter passes them
  task automatic common_clock_input_pulses(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      common_clock_input = 1'b1;
      repeat (2) @(negedge clk_sys);
      common_clock_input = 1'b0;
      @(negedge clk_sys);
    end
  endtask
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~data;
  endtask
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_sys);
    reg_addr = addr;
    @(negedge clk_sys);
    data = reg_rdata;
  endtask
  // strobe stops first: the core parks from its prefetch queue after the write
  task automatic force_down();
    ale_run = 1'b0;
    repeat (8) @(negedge clk_sys);
    write_reg(OFS_POWER_MODE_REG_THREE, 8'h0_002);
  endtask
endmodule

//--- verification/test_forced_powerdown_and_chip_gating.sv
// Purpose: scenario bench for the power gating block
// Assumes: inputs change on the falling edge
// Notes: common clock pulses only in t_auto, the one scenario that checks idle entry
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %0h want %0h", $time, got, exp); end end
module test_forced_powerdown_and_chip_gating
  import power_gate_pkg::*;
;
  logic clk_sys, rstn, reg_wr, csi_configured, low_voltage_part, ale, common_clock_input;
  logic csi_n, rd_n, wr_n, psen_n, pc7, fetch_enable, host_bus_block, fast_mode;
  logic logic_standby, csi_pin_level, powerdown_indicator;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, logic_array_in, logic_array_out, rd;
  logic [N_SEL-1:0] sel_request, mem_select;
  logic [4:0] logic_input_bus;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  forced_powerdown_and_chip_gating forced_powerdown_and_chip_gating_inst (.clk_sys, .rstn,
    .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .csi_configured, .low_voltage_part, .ale,
    .common_clock_input, .csi_n, .rd_n, .wr_n, .psen_n, .pc7, .sel_request, .mem_select,
    .fetch_enable, .host_bus_block, .logic_array_in, .logic_array_out, .logic_input_bus,
    .fast_mode, .logic_standby, .csi_pin_level, .powerdown_indicator);
  host_model host_model_inst (.clk_sys, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .ale,
    .common_clock_input, .csi_n);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic w(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic apply_reset();
    rstn = 1'b0;
    w(12);
    rstn = 1'b1;
  endtask
  task automatic give_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      $display("unexpected at %0t: run did not finish", $time);
      give_verdict();
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    `CHK(fast_mode, 1'b1)
    `CHK(fetch_enable, 1'b1)
    host_model_inst.read_reg(OFS_POWER_MODE_REG_ZERO, rd);
    `CHK(rd, REG_RESET)
    host_model_inst.read_reg(OFS_POWER_MODE_REG_THREE, rd);
    `CHK(rd, REG_RESET)
  endtask
  task automatic t_select();
    csi_configured = 1'b1;
    sel_request = 4'h0_00F;
    w(6);
    `CHK(mem_select, 4'h0_00F)
    rd = logic_array_out;
    host_model_inst.csi_n = 1'b1;
    w(6);
    `CHK(mem_select, 4'h0_000)
    `CHK(logic_array_out, rd)
    csi_configured = 1'b0;
    w(2);
    `CHK(mem_select, 4'h0_00F)
    `CHK(csi_pin_level, 1'b1)
  endtask
  task automatic t_block();
    `CHK(logic_input_bus[0], 1'b1)
    host_model_inst.write_reg(OFS_POWER_MODE_REG_TWO, 8'h0_0FF);
    host_model_inst.read_reg(OFS_POWER_MODE_REG_TWO, rd);
    `CHK(rd, MASK_REG_TWO)
    `CHK(logic_input_bus, 5'h0_000)
    host_model_inst.write_reg(OFS_POWER_MODE_REG_TWO, 8'h0_020);
    w(2);
    `CHK(logic_input_bus, 5'h0_017)
  endtask
  task automatic t_slow();
    low_voltage_part = 1'b1;
    host_model_inst.write_reg(OFS_POWER_MODE_REG_ZERO, 8'h0_008);
    w(5);
    `CHK(fast_mode, 1'b0)
    `CHK(logic_standby, 1'b1)
    sel_request = 4'h0_000;
    w(3);
    sel_request = 4'h0_001;
    w(1);
    `CHK(mem_select, 4'h0_000)
    w(1);
    `CHK(mem_select, 4'h0_001)
    host_model_inst.write_reg(OFS_POWER_MODE_REG_ZERO, 8'h0_000);
    w(2);
    `CHK(fast_mode, 1'b1)
  endtask
  task automatic t_force();
    sel_request = 4'h0_00F;
    host_model_inst.force_down();
    `CHK(powerdown_indicator, 1'b1)
    `CHK(fetch_enable, 1'b0)
    `CHK(host_bus_block, 1'b1)
    `CHK(mem_select, 4'h0_000)
    host_model_inst.write_reg(OFS_POWER_MODE_REG_THREE, 8'h0_000);
    host_model_inst.read_reg(OFS_POWER_MODE_REG_THREE, rd);
    `CHK(rd, 8'h0_002)
    host_model_inst.write_reg(OFS_POWER_MODE_REG_ZERO, 8'h0_002);
    w(20);
    `CHK(powerdown_indicator, 1'b1)
    host_model_inst.ale_run = 1'b1;
    w(8);
    `CHK(powerdown_indicator, 1'b0)
    host_model_inst.force_down();
    `CHK(powerdown_indicator, 1'b1)
    csi_configured = 1'b1;
    w(6);
    host_model_inst.csi_n = 1'b0;
    w(8);
    `CHK(powerdown_indicator, 1'b0)
    apply_reset();
    host_model_inst.read_reg(OFS_POWER_MODE_REG_THREE, rd);
    `CHK(rd, REG_RESET)
  endtask
  task automatic t_auto();
    host_model_inst.write_reg(OFS_POWER_MODE_REG_ZERO, 8'h0_002);
    host_model_inst.common_clock_input_pulses(int'(AUTO_IDLE_MAX) - 1);
    w(6);
    `CHK(powerdown_indicator, 1'b0)
    host_model_inst.common_clock_input_pulses(1);
    w(6);
    `CHK(powerdown_indicator, 1'b1)
    `CHK(fetch_enable, 1'b0)
  endtask
  initial begin
    csi_configured = 1'b0;
    low_voltage_part = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    psen_n = 1'b1;
    pc7 = 1'b1;
    sel_request = 4'h0_000;
    logic_array_in = 8'h0_05A;
    apply_reset();
    t_reset();
    t_select();
    t_block();
    t_slow();
    t_force();
    t_auto();
    give_verdict();
  end
endmodule
